// [hdl/pira_defs.svh]
// Register numbers, control-byte field positions, reset values and codes
`ifndef PIRA_DEFS_SVH
`define PIRA_DEFS_SVH

// Control-byte fields
`define PIRA_CTRL_REG_BIT    7
`define PIRA_CTRL_WR_BIT     6
`define PIRA_CTRL_NUM_MSB    5
`define PIRA_CTRL_NUM_LSB    0

// Register numbers
`define PIRA_REG_UNLOCK      6'h1F
`define PIRA_REG_FEATURE     6'h20

// Code word values
`define PIRA_UNLOCK_CODE     16'h1235
`define PIRA_LOCK_CODE       16'h0000

// Reset values
`define PIRA_UNLOCK_RESET    16'h0000
`define PIRA_FEATURE_RESET   16'h0000
`define PIRA_STATUS_RESET    8'h00
`define PIRA_WORD_RESET      16'h0000

// Feature bit positions
`define PIRA_FEAT_DC_BYPASS  4

`endif

// [hdl/pira_pkg.sv]
// Types shared by the register access block
package pira_pkg;

   typedef enum logic [1:0] {
      PIRA_IDLE,
      PIRA_READ,
      PIRA_WRITE
   } pira_access_e;

   typedef logic [15:0] pira_word_t;

endpackage : pira_pkg

// [hdl/pira_decode.sv]
// Control-byte decoder: classifies the cyclic exchange
`timescale 1ns/10ps
`include "pira_defs.svh"

module pira_decode
(
   input  wire logic [7:0]           ctrl_byte,
   output pira_pkg::pira_access_e    access,
   output logic      [5:0]           reg_num,
   output logic      [7:0]           ack_byte
);

   ////////////////////////////////////////////////////////////////////////////
   // Top bit switches to register mode, bit six picks direction
   always_comb
   begin
      reg_num = ctrl_byte[`PIRA_CTRL_NUM_MSB:`PIRA_CTRL_NUM_LSB]; // R3
      if (!ctrl_byte[`PIRA_CTRL_REG_BIT]) // R1
         access = pira_pkg::PIRA_IDLE;
      else if (ctrl_byte[`PIRA_CTRL_WR_BIT]) // R2
         access = pira_pkg::PIRA_WRITE;
      else
         access = pira_pkg::PIRA_READ;
      // Write receipt drops bit six, read receipt is the plain echo
      ack_byte = ctrl_byte;
      ack_byte[`PIRA_CTRL_WR_BIT] = 1'b0; // R4 R5
   end

endmodule : pira_decode

// [hdl/pira_regs.sv]
// Code word and feature registers with write protection
`timescale 1ns/10ps
`include "pira_defs.svh"

module pira_regs
(
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   input  wire logic                 wr_en,
   input  wire logic [5:0]           wr_num,
   input  wire pira_pkg::pira_word_t wr_data,
   output pira_pkg::pira_word_t      unlock_ff,
   output pira_pkg::pira_word_t      feature_ff,
   output logic                      unlocked
);

   ////////////////////////////////////////////////////////////////////////////
   // Only the exact code unlocks; anything else, 0x0000 included, locks
   assign unlocked = (unlock_ff == `PIRA_UNLOCK_CODE); // R13 R10

   // Code word register is always writable
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         unlock_ff <= `PIRA_UNLOCK_RESET;
      else if (wr_en && wr_num == `PIRA_REG_UNLOCK)
         unlock_ff <= wr_data; // R8 R10
   end

   // Feature register needs the unlock code; default keeps the DC filter in
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         feature_ff <= `PIRA_FEATURE_RESET; // R15
      else if (wr_en && unlocked && wr_num == `PIRA_REG_FEATURE)
         feature_ff <= wr_data; // R8 R13
   end

endmodule : pira_regs

// [hdl/pira_top.sv]
// Process-image register access: control/status byte exchange
// How it works
// R1: Control bit 7 selects register communication
// R2: Control bit 6 set writes, cleared reads
// R3: Low six bits give register number
// R4: Write receipt is control byte minus bit6
// R5: Read receipt echoes control byte unchanged
// R6: Input word invalid after a write
// R7: Output word ignored during reads
// R8: Write stores output word into register
// R9: Code word register reads back held value
// R10: Writing 0x0000 to code word locks
// R11: Feature register 32 reads its contents
// R12: DC filter on by default, bit4 disables
// R13: Only 0x1235 unlocks other user registers
// R14: Written settings apply after restart only; here reset also clears the feature register, so a written bypass never applies
// R15: Feature bit4 set bypasses DC filter
// R16: Host holds request until receipt appears
`timescale 1ns/10ps
`include "pira_defs.svh"

module pira_top
(
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   input  wire logic [7:0]           ctrl_byte,
   input  wire pira_pkg::pira_word_t host_out_word,
   input  wire pira_pkg::pira_word_t process_word,
   output logic      [7:0]           status_byte_ff,
   output pira_pkg::pira_word_t      terminal_in_word_ff,
   output logic                      dc_filter_bypass_ff,
   output logic                      write_unlocked_ff
);

   pira_pkg::pira_access_e access;
   logic [5:0]             reg_num;
   logic [7:0]             ack_byte;
   logic                   wr_en;
   logic                   unlocked;
   pira_pkg::pira_word_t   unlock_val;
   pira_pkg::pira_word_t   feature_val;
   pira_pkg::pira_word_t   nxt_in_word;
   logic [7:0]             last_ctrl_ff;
   logic                   boot_done_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Control-byte decode
   pira_decode u_decode
   (
      .ctrl_byte (ctrl_byte),
      .access    (access),
      .reg_num   (reg_num),
      .ack_byte  (ack_byte)
   );

   ////////////////////////////////////////////////////////////////////////////
   // One write per new control byte; host holds it until receipt
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         last_ctrl_ff <= `PIRA_STATUS_RESET;
      else
         last_ctrl_ff <= ctrl_byte; // R16
   end

   assign wr_en = (access == pira_pkg::PIRA_WRITE) && (ctrl_byte != last_ctrl_ff);

   ////////////////////////////////////////////////////////////////////////////
   // Register storage
   pira_regs u_regs
   (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .wr_en      (wr_en),
      .wr_num     (reg_num),
      .wr_data    (host_out_word),
      .unlock_ff  (unlock_val),
      .feature_ff (feature_val),
      .unlocked   (unlocked)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Receipt byte; in process-data mode the status shows zero
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         status_byte_ff <= `PIRA_STATUS_RESET;
      else if (access == pira_pkg::PIRA_WRITE)
         status_byte_ff <= ack_byte; // R4
      else if (access == pira_pkg::PIRA_READ)
         status_byte_ff <= ctrl_byte; // R5
      else
         status_byte_ff <= `PIRA_STATUS_RESET;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input word source; reads never look at host_out_word
   always_comb
   begin
      nxt_in_word = `PIRA_WORD_RESET;
      case (access)
         pira_pkg::PIRA_READ:
         begin
            if (reg_num == `PIRA_REG_UNLOCK)
               nxt_in_word = unlock_val; // R9 R7
            else if (reg_num == `PIRA_REG_FEATURE)
               nxt_in_word = feature_val; // R11 R7
            else
               nxt_in_word = `PIRA_WORD_RESET;
         end
         pira_pkg::PIRA_WRITE:
            nxt_in_word = `PIRA_WORD_RESET; // R6
         pira_pkg::PIRA_IDLE:
            nxt_in_word = process_word; // R1
         default:
            nxt_in_word = `PIRA_WORD_RESET;
      endcase
   end

   // Registered input word
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         terminal_in_word_ff <= `PIRA_WORD_RESET;
      else
         terminal_in_word_ff <= nxt_in_word;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Feature bit copied once after reset release, but reset also clears the feature register, so the copy is always 0
   // and a written bypass never acts; reset stands in for the power cycle
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         boot_done_ff        <= 1'b0;
         dc_filter_bypass_ff <= 1'b0; // R12
      end
      else if (!boot_done_ff)
      begin
         boot_done_ff        <= 1'b1;
         dc_filter_bypass_ff <= feature_val[`PIRA_FEAT_DC_BYPASS]; // R14 R15
      end
   end

   // Lock state for the measurement side
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         write_unlocked_ff <= 1'b0;
      else
         write_unlocked_ff <= unlocked; // R13
   end

endmodule : pira_top

// [dv/pira_top_props.sv]
// Port checker for the register access block
`timescale 1ns/10ps
module pira_top_props
(
   input wire logic                 ref_clk,
   input wire logic                 reset,
   input wire logic [7:0]           ctrl_byte,
   input wire pira_pkg::pira_word_t host_out_word,
   input wire pira_pkg::pira_word_t process_word,
   input wire logic [7:0]           status_byte_ff,
   input wire pira_pkg::pira_word_t terminal_in_word_ff,
   input wire logic                 dc_filter_bypass_ff,
   input wire logic                 write_unlocked_ff
);
   // One clock domain; quiet while reset holds
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_write_receipt:
   assert property (&ctrl_byte[7:6] |=> status_byte_ff == ($past(ctrl_byte) & 8'hBF))
      else $error("bad write receipt");
   a_write_word:
   assert property (&ctrl_byte[7:6] |=> terminal_in_word_ff == 16'h0000)
      else $error("word not cleared after write");
   a_read_receipt:
   assert property (ctrl_byte[7:6] == 2'b10 |=> status_byte_ff == $past(ctrl_byte))
      else $error("bad read receipt");
   a_process_pass:
   assert property (!ctrl_byte[7] |=> status_byte_ff == 8'h00
      && terminal_in_word_ff == $past(process_word)) else $error("process data wrong");
   a_unlock_flag:
   assert property (ctrl_byte == 8'hDF && host_out_word == 16'h1235 && $changed(ctrl_byte)
      |=> ##1 write_unlocked_ff) else $error("unlock missed");
   a_lock_flag:
   assert property (ctrl_byte == 8'hDF && host_out_word == 16'h0000 && $changed(ctrl_byte)
      |=> ##1 !write_unlocked_ff) else $error("lock missed");
   a_code_read:
   assert property (write_unlocked_ff && ctrl_byte == 8'h9F |=> terminal_in_word_ff == 16'h1235)
      else $error("code word readback wrong");
   a_bypass_held:
   assert property ($stable(dc_filter_bypass_ff)) else $error("bypass moved without restart");
   // Main scenarios reached
   c_unlock: cover property ($rose(write_unlocked_ff));
   c_feature: cover property (ctrl_byte == 8'hA0 ##1 terminal_in_word_ff != 16'h0000);
   c_process: cover property (!ctrl_byte[7]);
endmodule : pira_top_props

bind pira_top pira_top_props u_props (.*);

// [dv/pira_host_model.sv]
// Host side model: launches and holds each register request
`timescale 1ns/10ps
module pira_host_model
(
   input wire logic                 ref_clk,
   input wire logic [7:0]           req_ctrl,
   input wire pira_pkg::pira_word_t req_word,
   input wire logic [7:0]           status_byte_ff,
   output logic [7:0]               ctrl_byte,
   output pira_pkg::pira_word_t     host_out_word,
   output logic                     receipt_seen
);
   // Reads carry junk in the word, as a real host may
   always_ff @(posedge ref_clk)
   begin
      ctrl_byte     <= req_ctrl;
      host_out_word <= req_ctrl[6] ? req_word : ~req_word;
   end
   // Receipt match: bit 6 dropped on writes only
   assign receipt_seen = ctrl_byte[7]
      && status_byte_ff == (ctrl_byte & {1'b1, ~ctrl_byte[6], 6'h3F});
endmodule : pira_host_model

// [dv/process_image_register_access_bench.sv]
// Self-checking bench for the register access block
`timescale 1ns/10ps
module process_image_register_access_bench;
   logic                 ref_clk;
   logic                 reset = 1'b1;
   logic [7:0]           req_ctrl = 8'h00;
   pira_pkg::pira_word_t req_word = 16'h0000;
   pira_pkg::pira_word_t process_word = 16'h5A3C;
   logic [7:0]           ctrl_byte;
   pira_pkg::pira_word_t host_out_word;
   logic [7:0]           status_byte_ff;
   pira_pkg::pira_word_t terminal_in_word_ff;
   logic                 dc_filter_bypass_ff;
   logic                 write_unlocked_ff;
   logic                 receipt_seen;
   logic [7:0]           c;
   logic [7:0]           s;
   pira_pkg::pira_word_t w;
   pira_pkg::pira_word_t e;
   int                   err_total = 0;
   int                   checks = 0;
   logic [47:0]          rows [13];

   pira_top dut (.*);
   pira_host_model u_host (.*);

   ////////////////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic print_verdict;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   // Fixed latency: host edge, then design edge
   task automatic apply(input logic [7:0] cb, input pira_pkg::pira_word_t wd);
      @(posedge ref_clk);
      req_ctrl <= cb;
      req_word <= wd;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : apply

   ////////////////////////////////////////////////////////////////////////////////
   // Row: control, out word, expected status, expected in word
   initial
   begin
      rows = '{{8'h9F, 16'h4321, 8'h9F, 16'h0000}, {8'hA0, 16'h0000, 8'hA0, 16'h0000},
               {8'hE0, 16'h0010, 8'hA0, 16'h0000}, {8'hA0, 16'h0000, 8'hA0, 16'h0000},
               {8'hDF, 16'h1235, 8'h9F, 16'h0000}, {8'h9F, 16'h0000, 8'h9F, 16'h1235},
               {8'hE0, 16'h0012, 8'hA0, 16'h0000}, {8'hA0, 16'hFFFF, 8'hA0, 16'h0012},
               {8'h89, 16'h0000, 8'h89, 16'h0000}, {8'hDF, 16'h0000, 8'h9F, 16'h0000},
               {8'hE0, 16'h0000, 8'hA0, 16'h0000}, {8'hA0, 16'h0000, 8'hA0, 16'h0012},
               {8'h05, 16'h0000, 8'h00, 16'h5A3C}};
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      foreach (rows[i])
      begin
         {c, w, s, e} = rows[i];
         apply(c, w);
         cmp({8'h00, status_byte_ff}, {8'h00, s});
         cmp(terminal_in_word_ff, e);
         cmp({15'h0000, receipt_seen}, {15'h0000, c[7]});
      end
      // Unlock, then a bypass write must wait for a restart
      apply(8'hDF, 16'h1235);
      @(posedge ref_clk);
      #1;
      cmp({15'h0000, write_unlocked_ff}, 16'h0001);
      apply(8'hE0, 16'h0010);
      cmp({15'h0000, dc_filter_bypass_ff}, 16'h0000);
      // Restart: filter back in the path, registers cleared
      @(posedge ref_clk);
      reset <= 1'b1;
      req_ctrl <= 8'h00;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      apply(8'hA0, 16'h0000);
      cmp({15'h0000, dc_filter_bypass_ff}, 16'h0000);
      cmp(terminal_in_word_ff, 16'h0000);
      cmp({15'h0000, write_unlocked_ff}, 16'h0000);
      print_verdict();
   end

   // Watchdog well past the expected run length
   initial
   begin
      #(50 * 400);
      err_total++;
      print_verdict();
   end
endmodule : process_image_register_access_bench
